// [verilog/stack_cap_esr_test_sequencer.sv]
`timescale 1ns/100ps
`include "stack_test_map.svh"
// ****************************************************************
// Operation
// - pre-charge stack by 1.25 times voltage step
// - sink on, settle, sample, time step fall
// - nonzero override fixes current, stops adjustment
// - auto-chosen next current readable by software
// - falling charge current lowers next current
// - active alert holds line low until cleared
// - start bit begins cycle, resistance test first
// - current on, wait, off, wait; zero allowed
// - keep early and late current samples
// - sink enable and esr-done alarm together
// - settle counts in converter clock ticks
// - report totals, keep raw samples readable
// - start bit clears once cycle begins
// - abort stops cycle, bit self-clears
// - small-cap scale gives 100x finer count
// ****************************************************************
module stack_cap_esr_test_sequencer #(
  parameter int DW    = 16,
  parameter int CAP_W = 24
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic      [31:0]       HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  input  wire logic              SW_TICK,
  input  wire logic [DW-1:0]     VCAP_CODE,
  input  wire logic [DW-1:0]     ICHG_CODE,
  output logic                   CHARGE_TEST_EN,
  output logic [DW-1:0]          TEST_CURRENT_SET,
  output logic                   TEST_SINK_DRIVE,
  output logic                   ALERT_N,
  output logic                   IRQ
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // converter codes are assumed to hold steady for many cycles; a two-flop
  // stage on a bus only filters metastability, not skew between bits
  logic          tick_m_q, tick_s_q, tick_p_q;
  logic [DW-1:0] vcap_m_q, vcap_q, ichg_m_q, ichg_q;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tick_m_q <= 1'b0;
      tick_s_q <= 1'b0;
      tick_p_q <= 1'b0;
      vcap_m_q <= '0;
      vcap_q   <= '0;
      ichg_m_q <= '0;
      ichg_q   <= '0;
    end else begin
      tick_m_q <= SW_TICK;
      tick_s_q <= tick_m_q;
      tick_p_q <= tick_s_q;
      vcap_m_q <= VCAP_CODE;
      vcap_q   <= vcap_m_q;
      ichg_m_q <= ICHG_CODE;
      ichg_q   <= ichg_m_q;
    end
  end
  logic tick;
  assign tick = tick_s_q & ~tick_p_q;

  // ****************************************************************
  // register state and sequencer state
  // ****************************************************************
  stack_test_pkg::seq_state_e state_q;
  stack_test_pkg::event_t     status_q, mask_q, ev;
  logic             start_q, abort_q, scale_q, active_q;
  logic [DW-1:0]    override_q, next_i_q, on_set_q, off_set_q, cap_set_q, dv_q;
  logic [DW-1:0]    i1_q, i2_q, v_start_q, v_on_q, v_off_q, v1_q, esr_q, cnt_q;
  logic [CAP_W-1:0] cap_cnt_q, cap_res_q;
  logic [6:0]       div_q;
  logic             wr_q;
  logic [7:0]       addr_q;

  logic begin_w, stop_w, on_done, off_done, pre_done, cset_done, ctime_done;
  logic [DW+1:0] pre_target;
  assign begin_w    = (state_q == stack_test_pkg::S_IDLE) && start_q && !abort_q;
  assign stop_w     = abort_q && (state_q != stack_test_pkg::S_IDLE);
  assign on_done    = tick && (cnt_q + 16'h0001 >= on_set_q);
  assign off_done   = (off_set_q == '0) || (tick && (cnt_q + 16'h0001 >= off_set_q));
  assign pre_target = {2'b00, v_start_q} + {2'b00, dv_q} + {4'h0, dv_q[DW-1:2]};
  assign pre_done   = {2'b00, vcap_q} >= pre_target;
  assign cset_done  = tick && (cnt_q + 16'h0001 >= cap_set_q);
  assign ctime_done = ({1'b0, vcap_q} + {1'b0, dv_q}) <= {1'b0, v1_q};
  always_comb begin
    ev = '0;
    ev[`EV_MEAS_ACTIVE] = begin_w;
    ev[`EV_ESR_DONE]    = !stop_w && (state_q == stack_test_pkg::S_PRE) && pre_done;
    ev[`EV_CAP_DONE]    = !stop_w && (state_q == stack_test_pkg::S_CTIME) && ctime_done;
  end

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  // zero-wait: reads are fetched in the address phase into a flop
  logic sel;
  assign sel = HSEL && HTRANS[1] && HREADY;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `ADDR_CTRL:       r = {28'h0, scale_q, abort_q, 1'b0, start_q};
      `ADDR_INT_STATUS: r = {29'h0, status_q};
      `ADDR_INT_MASK:   r = {29'h0, mask_q};
      `ADDR_I_OVERRIDE: r = {16'h0, override_q};
      `ADDR_NEXT_I:     r = {16'h0, next_i_q};
      `ADDR_ON_SETTLE:  r = {16'h0, on_set_q};
      `ADDR_OFF_SETTLE: r = {16'h0, off_set_q};
      `ADDR_CAP_SETTLE: r = {16'h0, cap_set_q};
      `ADDR_DELTA_V:    r = {16'h0, dv_q};
      `ADDR_I_SAMPLE1:  r = {16'h0, i1_q};
      `ADDR_I_SAMPLE2:  r = {16'h0, i2_q};
      `ADDR_V_SAMPLES:  r = {v_on_q, v_off_q};
      `ADDR_ESR_RESULT: r = {16'h0, esr_q};
      `ADDR_CAP_RESULT: r = {8'h0, cap_res_q};
      `ADDR_SEQ_STATUS: r = {28'h0, active_q, state_q};
      default:          r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      wr_q      <= sel && HWRITE;
      addr_q    <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (sel && !HWRITE)
        HRDATA <= rd_mux(HADDR[7:0]);
    end
  end

  // ****************************************************************
  // control and settings registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      start_q    <= 1'b0;
      abort_q    <= 1'b0;
      scale_q    <= 1'b0;
      mask_q     <= '0;
      override_q <= '0;
      on_set_q   <= `RST_ON_SETTLE;
      off_set_q  <= `RST_OFF_SETTLE;
      cap_set_q  <= `RST_CAP_SETTLE;
      dv_q       <= `RST_DELTA_V;
    end else begin
      if (begin_w)
        start_q <= 1'b0;
      if (abort_q && (state_q == stack_test_pkg::S_IDLE))
        abort_q <= 1'b0;
      if (wr_q) begin
        unique case (addr_q)
          `ADDR_CTRL: begin
            if (HWDATA[`CTRL_START])
              start_q <= 1'b1;
            if (HWDATA[`CTRL_ABORT])
              abort_q <= 1'b1;
            scale_q <= HWDATA[`CTRL_CAP_SCALE];
          end
          `ADDR_INT_MASK:   mask_q     <= HWDATA[2:0];
          `ADDR_I_OVERRIDE: override_q <= HWDATA[DW-1:0];
          `ADDR_ON_SETTLE:  on_set_q   <= HWDATA[DW-1:0];
          `ADDR_OFF_SETTLE: off_set_q  <= HWDATA[DW-1:0];
          `ADDR_CAP_SETTLE: cap_set_q  <= HWDATA[DW-1:0];
          `ADDR_DELTA_V:    dv_q       <= HWDATA[DW-1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // interrupt status, alert line
  // ****************************************************************
  // a set in the same cycle as a write-one-to-clear survives
  stack_test_pkg::event_t clr;
  assign clr = (wr_q && addr_q == `ADDR_INT_STATUS) ? HWDATA[2:0] : '0;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      status_q <= '0;
      IRQ      <= 1'b0;
      ALERT_N  <= 1'b1;
    end else begin
      status_q <= (status_q & ~clr) | ev;
      IRQ      <= |(status_q & mask_q);
      ALERT_N  <= ~|(status_q & mask_q);
    end
  end

  // ****************************************************************
  // measurement sequencer
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q          <= stack_test_pkg::S_IDLE;
      active_q         <= 1'b0;
      cnt_q            <= '0;
      div_q            <= '0;
      cap_cnt_q        <= '0;
      cap_res_q        <= '0;
      next_i_q         <= `RST_NEXT_I;
      i1_q             <= '0;
      i2_q             <= '0;
      v_start_q        <= '0;
      v_on_q           <= '0;
      v_off_q          <= '0;
      v1_q             <= '0;
      esr_q            <= '0;
      CHARGE_TEST_EN   <= 1'b0;
      TEST_SINK_DRIVE  <= 1'b0;
      TEST_CURRENT_SET <= '0;
    end else if (stop_w) begin
      // partial samples of an aborted cycle never reach the result registers
      state_q         <= stack_test_pkg::S_IDLE;
      active_q        <= 1'b0;
      CHARGE_TEST_EN  <= 1'b0;
      TEST_SINK_DRIVE <= 1'b0;
    end else begin
      unique case (state_q)
        stack_test_pkg::S_IDLE: if (begin_w) begin
          state_q          <= stack_test_pkg::S_ON;
          active_q         <= 1'b1;
          cnt_q            <= '0;
          v_start_q        <= vcap_q;
          CHARGE_TEST_EN   <= 1'b1;
          TEST_CURRENT_SET <= (override_q != '0) ? override_q : next_i_q;
        end
        stack_test_pkg::S_ON: if (tick) begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == '0)
            i1_q <= ichg_q;
          if (on_done) begin
            i2_q           <= ichg_q;
            v_on_q         <= vcap_q;
            CHARGE_TEST_EN <= 1'b0;
            cnt_q          <= '0;
            state_q        <= stack_test_pkg::S_OFF;
            if (override_q == '0 && ichg_q < i1_q)
              next_i_q <= next_i_q - {3'b000, next_i_q[DW-1:3]};
          end
        end
        stack_test_pkg::S_OFF: begin
          if (off_done) begin
            v_off_q        <= vcap_q;
            cnt_q          <= '0;
            CHARGE_TEST_EN <= 1'b1;
            state_q        <= stack_test_pkg::S_PRE;
          end else if (tick)
            cnt_q <= cnt_q + 16'h0001;
        end
        stack_test_pkg::S_PRE: if (pre_done) begin
          CHARGE_TEST_EN  <= 1'b0;
          TEST_SINK_DRIVE <= 1'b1;
          state_q         <= stack_test_pkg::S_CSET;
        end
        stack_test_pkg::S_CSET: if (tick) begin
          cnt_q <= cnt_q + 16'h0001;
          if (cset_done) begin
            v1_q      <= vcap_q;
            cap_cnt_q <= '0;
            div_q     <= '0;
            state_q   <= stack_test_pkg::S_CTIME;
          end
        end
        stack_test_pkg::S_CTIME: begin
          if (ctime_done) begin
            cap_res_q       <= cap_cnt_q;
            esr_q           <= v_on_q - v_off_q;
            TEST_SINK_DRIVE <= 1'b0;
            active_q        <= 1'b0;
            state_q         <= stack_test_pkg::S_IDLE;
          end else if (tick) begin
            // large scale advances once per hundred ticks
            if (scale_q || div_q == `LARGE_CAP_DIV - 7'd1) begin
              cap_cnt_q <= cap_cnt_q + 24'h000001;
              div_q     <= '0;
            end else
              div_q <= div_q + 7'd1;
          end
        end
        // codes 6 and 7 are unused; fall back to idle rather than lock up
        default: state_q <= stack_test_pkg::S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_begin_runs_esr_first;
    @(posedge CLK) disable iff (SYS_RST)
    begin_w |=> state_q == stack_test_pkg::S_ON && CHARGE_TEST_EN && active_q && !start_q;
  endproperty
  a_begin_runs_esr_first: assert property (p_begin_runs_esr_first) else $error("start did not begin esr");

  property p_start_clears;
    @(posedge CLK) disable iff (SYS_RST)
    begin_w && !(wr_q && addr_q == `ADDR_CTRL) |=> !start_q;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start bit stuck");

  property p_abort_stops;
    @(posedge CLK) disable iff (SYS_RST)
    stop_w |=> state_q == stack_test_pkg::S_IDLE && !active_q && !TEST_SINK_DRIVE ##1 !abort_q;
  endproperty
  a_abort_stops: assert property (p_abort_stops) else $error("abort did not stop");

  property p_override_current;
    @(posedge CLK) disable iff (SYS_RST)
    begin_w && override_q != '0 |=> TEST_CURRENT_SET == $past(override_q);
  endproperty
  a_override_current: assert property (p_override_current) else $error("override ignored");

  property p_override_freezes;
    @(posedge CLK) disable iff (SYS_RST)
    override_q != '0 && $stable(override_q) |-> $stable(next_i_q);
  endproperty
  a_override_freezes: assert property (p_override_freezes) else $error("auto current moved");

  property p_sink_with_esr_done;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(TEST_SINK_DRIVE) |-> status_q[`EV_ESR_DONE] && !CHARGE_TEST_EN;
  endproperty
  a_sink_with_esr_done: assert property (p_sink_with_esr_done) else $error("sink without alarm");

  property p_precharge_level;
    @(posedge CLK) disable iff (SYS_RST)
    state_q == stack_test_pkg::S_PRE ##1 state_q == stack_test_pkg::S_CSET |-> $past(pre_done);
  endproperty
  a_precharge_level: assert property (p_precharge_level) else $error("precharge short");

  property p_off_zero;
    @(posedge CLK) disable iff (SYS_RST)
    state_q == stack_test_pkg::S_OFF && off_set_q == '0 && !stop_w |=> state_q == stack_test_pkg::S_PRE;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("zero off wait stalled");

  property p_alert_holds;
    @(posedge CLK) disable iff (SYS_RST)
    status_q[`EV_MEAS_ACTIVE] && mask_q[`EV_MEAS_ACTIVE] && !clr[`EV_MEAS_ACTIVE]
      |=> !ALERT_N && status_q[`EV_MEAS_ACTIVE];
  endproperty
  a_alert_holds: assert property (p_alert_holds) else $error("alert released early");

  property p_active_span;
    @(posedge CLK) disable iff (SYS_RST)
    active_q == (state_q != stack_test_pkg::S_IDLE);
  endproperty
  a_active_span: assert property (p_active_span) else $error("active flag mismatch");
endmodule // stack_cap_esr_test_sequencer

// [pkg/stack_test_map.svh]
`ifndef STACK_TEST_MAP_SVH
`define STACK_TEST_MAP_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define ADDR_CTRL        8'h00
`define ADDR_INT_STATUS  8'h04
`define ADDR_INT_MASK    8'h08
`define ADDR_I_OVERRIDE  8'h0c
`define ADDR_NEXT_I      8'h10
`define ADDR_ON_SETTLE   8'h14
`define ADDR_OFF_SETTLE  8'h18
`define ADDR_CAP_SETTLE  8'h1c
`define ADDR_DELTA_V     8'h20
`define ADDR_I_SAMPLE1   8'h24
`define ADDR_I_SAMPLE2   8'h28
`define ADDR_V_SAMPLES   8'h2c
`define ADDR_ESR_RESULT  8'h30
`define ADDR_CAP_RESULT  8'h34
`define ADDR_SEQ_STATUS  8'h38
// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_START       0
`define CTRL_ABORT       2
`define CTRL_CAP_SCALE   3
`define EV_MEAS_ACTIVE   0
`define EV_ESR_DONE      1
`define EV_CAP_DONE      2
// ****************************************************************
// reset values and counts
// ****************************************************************
`define RST_NEXT_I       16'h0400
`define RST_ON_SETTLE    16'h0040
`define RST_OFF_SETTLE   16'h0010
`define RST_CAP_SETTLE   16'h0100
`define RST_DELTA_V      16'h0200
`define LARGE_CAP_DIV    7'd100
`endif

// [pkg/stack_test_pkg.sv]
package stack_test_pkg;
  typedef enum logic [2:0] {S_IDLE, S_ON, S_OFF, S_PRE, S_CSET, S_CTIME} seq_state_e;
  typedef logic [2:0] event_t;
endpackage

// [verif/stack_sink_model.sv]
`timescale 1ns/100ps
// ****************************************************************
// capacitor stack and test sink
// ****************************************************************
module stack_sink_model (
  input  wire logic        clk,
  input  wire logic        charge_en,
  input  wire logic [15:0] i_set,
  input  wire logic        sink_en,
  input  wire logic        taper,
  output logic             tick,
  output logic [3:0]       phase,
  output logic [15:0]      vcap,
  output logic [15:0]      ichg
);
  logic [3:0]  ph_q  = 4'h0;
  logic [15:0] v_q   = 16'h4000;
  logic [15:0] i_q   = 16'h0000;
  logic        chg_q = 1'b0;
  // converter clock runs free; levels move mid-period so every tick sees settled codes
  always @(posedge clk) begin
    ph_q <= ph_q + 4'h1;
    chg_q <= charge_en;
    if (charge_en && !chg_q) begin
      i_q <= i_set;
    end
    if (ph_q == 4'h8) begin
      if (charge_en) begin
        v_q <= v_q + 16'h0010;
      end else if (sink_en) begin
        v_q <= v_q - 16'h0002;
      end
      // a stack nearing full charge draws less current
      if (charge_en && chg_q && taper) begin
        i_q <= i_q - 16'h0008;
      end
    end
  end
  assign tick  = (ph_q < 4'h2);
  assign phase = ph_q;
  // series resistance lifts the terminal voltage while charge flows
  assign vcap  = v_q + (charge_en ? 16'h0020 : 16'h0000);
  assign ichg  = charge_en ? (chg_q ? i_q : i_set) : 16'h0000;
endmodule // stack_sink_model

// [verif/tb_top.sv]
`timescale 1ns/100ps
`include "stack_test_map.svh"
module tb_top;
  logic        clk, sys_rst, hwrite, hreadyout, hresp, tick, chg_en, sink, alert_n, irq, taper;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q, ovr, cap_prev;
  logic [15:0] vcap, ichg, i_set, v_chg;
  logic [3:0]  phase;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          seed = 32'ha85a;
  int          next_i, v0;
  logic [7:0]  ra[6] = '{`ADDR_NEXT_I, `ADDR_ON_SETTLE, `ADDR_OFF_SETTLE, `ADDR_CAP_SETTLE, `ADDR_DELTA_V, 8'h3c};
  logic [31:0] rv[6] = '{`RST_NEXT_I, `RST_ON_SETTLE, `RST_OFF_SETTLE, `RST_CAP_SETTLE, `RST_DELTA_V, 32'h0};
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  stack_cap_esr_test_sequencer stack_cap_esr_test_sequencer_inst (.CLK(clk), .SYS_RST(sys_rst), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SW_TICK(tick), .VCAP_CODE(vcap), .ICHG_CODE(ichg),
    .CHARGE_TEST_EN(chg_en), .TEST_CURRENT_SET(i_set), .TEST_SINK_DRIVE(sink), .ALERT_N(alert_n), .IRQ(irq));
  stack_sink_model stack_sink_model_inst (.clk(clk), .charge_en(chg_en), .i_set(i_set), .sink_en(sink),
    .taper(taper), .tick(tick), .phase(phase), .vcap(vcap), .ichg(ichg));
  always @(posedge clk) if (chg_en) v_chg <= vcap;
  // ****************************************************************
  // bus cycles and comparisons
  // ****************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic fail(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask
  task automatic cmp_near(input logic [31:0] got, input int exp, input int tol, input string m);
    cmp_count++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) < exp - tol) fail(m);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    q = hrdata;
    if (n >= 20) begin fail("bus hang"); end_of_test(); end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    ahb(1'b0, a, 32'h0);
    cmp_val(q, exp, m);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin ahb(1'b0, a, 32'h0); n++; end while (q[b] !== v && n < 4000);
    if (n >= 4000) begin fail("wait expired"); end_of_test(); end
  endtask
  // start lands just after a stack update so the first tick sees settled codes
  task automatic start_aligned(input logic scale);
    int n;
    n = 0;
    while (phase !== 4'h9 && n < 20) begin @(posedge clk); n++; end
    if (n >= 20) begin fail("converter phase lost"); end_of_test(); end
    v0 = vcap;
    ahb(1'b1, `ADDR_CTRL, {28'h0, scale, 3'h1});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    sys_rst = 1'b1; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0; taper = 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rdchk(ra[i], rv[i], "reset value");
    cmp_val({alert_n, irq, chg_en, sink}, 4'b1000, "idle outputs");
    cmp_val({hreadyout, hresp}, 2'b10, "bus response");
    ahb(1'b1, 8'h3c, 32'hffff_ffff);
    rdchk(8'h3c, 32'h0, "unmapped read");
    ahb(1'b1, `ADDR_NEXT_I, 32'h1234);
    rdchk(`ADDR_NEXT_I, `RST_NEXT_I, "next current writable");
    // settle of 8 ticks stays under a quarter of the 256-tick discharge
    ahb(1'b1, `ADDR_ON_SETTLE, 32'h4);
    ahb(1'b1, `ADDR_OFF_SETTLE, 32'h2);
    ahb(1'b1, `ADDR_CAP_SETTLE, 32'h8);
    ahb(1'b1, `ADDR_INT_MASK, 32'h1);
    next_i = 32'h400;
    // stack starts well below full scale, leaving pre-charge headroom
    start_aligned(1'b1);
    // the start lands at the end of its data phase; the cycle begins one edge later
    repeat (2) @(posedge clk);
    rdchk(`ADDR_SEQ_STATUS, 32'h9, "resistance test first");
    poll(`ADDR_INT_STATUS, 0, 1'b1);
    rdchk(`ADDR_CTRL, 32'h8, "start bit stuck");
    cmp_val({alert_n, irq}, 2'b01, "alert on start");
    cmp_val(i_set, next_i, "auto current");
    ahb(1'b1, `ADDR_INT_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    cmp_val({alert_n, irq}, 2'b10, "alert clear");
    poll(`ADDR_INT_STATUS, 1, 1'b1);
    cmp_val(sink, 1'b1, "sink with esr done");
    cmp_val(32'(int'(v_chg) >= v0 + 640), 32'h1, "pre-charge short");
    poll(`ADDR_INT_STATUS, 2, 1'b1);
    cmp_val({sink, irq, chg_en}, 3'b000, "end outputs");
    rdchk(`ADDR_SEQ_STATUS, 32'h0, "still active");
    rdchk(`ADDR_I_SAMPLE1, next_i, "early sample");
    ahb(1'b0, `ADDR_I_SAMPLE2, 32'h0);
    cmp_near(q, next_i - 28, 4, "late sample");
    next_i = next_i - (next_i >> 3);
    rdchk(`ADDR_NEXT_I, next_i, "current not lowered");
    rdchk(`ADDR_ESR_RESULT, 32'h20, "esr total");
    ahb(1'b0, `ADDR_V_SAMPLES, 32'h0);
    cmp_val(32'(q[31:16] - q[15:0]), 32'h20, "voltage samples");
    ahb(1'b0, `ADDR_CAP_RESULT, 32'h0);
    cmp_near(q, 256, 1, "fine count");
    ovr = 32'h0200 + ($random(seed) & 32'hff);
    ahb(1'b1, `ADDR_I_OVERRIDE, ovr);
    ahb(1'b1, `ADDR_OFF_SETTLE, 32'h0);
    ahb(1'b1, `ADDR_INT_STATUS, 32'h7);
    start_aligned(1'b0);
    poll(`ADDR_INT_STATUS, 0, 1'b1);
    cmp_val(i_set, ovr, "forced current");
    poll(`ADDR_INT_STATUS, 2, 1'b1);
    rdchk(`ADDR_NEXT_I, next_i, "adjusted under override");
    ahb(1'b0, `ADDR_CAP_RESULT, 32'h0);
    cmp_near(q, 2, 1, "coarse count");
    cap_prev = q;
    ahb(1'b1, `ADDR_I_OVERRIDE, 32'h0);
    ahb(1'b1, `ADDR_OFF_SETTLE, 32'h2);
    ahb(1'b1, `ADDR_INT_STATUS, 32'h7);
    start_aligned(1'b1);
    poll(`ADDR_INT_STATUS, 0, 1'b1);
    cmp_val(i_set, next_i, "auto current back");
    ahb(1'b1, `ADDR_CTRL, 32'h4);
    poll(`ADDR_SEQ_STATUS, 3, 1'b0);
    repeat (2) @(posedge clk);
    rdchk(`ADDR_CTRL, 32'h0, "abort bit stuck");
    cmp_val({chg_en, sink}, 2'b00, "outputs after abort");
    rdchk(`ADDR_CAP_RESULT, cap_prev, "partial result kept");
    rdchk(`ADDR_INT_STATUS, 32'h1, "done after abort");
    rdchk(`ADDR_NEXT_I, next_i, "aborted adjust");
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail("run too long");
    end_of_test();
  end
endmodule // tb_top
